// *** design/pmt_bank.sv ***
/*
 * Register bank: burst timing, link-up time and common control.
 * Assumes writes arrive as one-cycle strobes from the portal.
 */
`timescale 1ns/1ns
`default_nettype none
module pmt_bank
	import pmt_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_n_i,
	pmt_bank_if.bank bus
);
	logic [8:0] linkup;
	logic [15:0] common_rw;

	// Address match helper
	function automatic logic hit(input logic [4:0] d, input logic [15:0] a,
		input logic [4:0] dd, input logic [15:0] aa);
		hit = (d == dd) && (a == aa);
	endfunction

	logic wr_common;
	assign wr_common = bus.wr && hit(bus.dev, bus.addr, DEV_COMMON, REG_COMMON);

	// Burst timing registers
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			bus.flp_low <= FLP_LOW_8MS;
			bus.flp_high <= FLP_HIGH_8MS;
		end else if (bus.wr) begin
			if (hit(bus.dev, bus.addr, DEV_AUTONEG, REG_FLP_LOW))
				bus.flp_low <= bus.wdata;
			if (hit(bus.dev, bus.addr, DEV_AUTONEG, REG_FLP_HIGH))
				bus.flp_high <= bus.wdata;
		end
	end

	// Link-up time control
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			linkup <= LINKUP_RST;
		else if (bus.wr && hit(bus.dev, bus.addr, DEV_LINKUP, REG_LINKUP))
			linkup <= bus.wdata[LINKUP_W-1:0];
	end
	assign bus.linkup_time = linkup[LUT_HI:LUT_LO];

	// Common control plain bits
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			common_rw <= COMMON_RST;
		else if (wr_common)
			common_rw <= bus.wdata & COMMON_RW_MASK;
	end

	// Indicator style: strap at release, then override writes
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			bus.style_status <= 1'b0;
		else if (wr_common)
			bus.style_status <= bus.wdata[OVR_BIT];
		else if (bus.strap_load)
			bus.style_status <= bus.strap;
	end

	// Read mux; override bit always reads zero
	always_comb begin
		bus.rdata = 16'h0000;
		if (hit(bus.dev, bus.addr, DEV_AUTONEG, REG_FLP_LOW))
			bus.rdata = bus.flp_low;
		else if (hit(bus.dev, bus.addr, DEV_AUTONEG, REG_FLP_HIGH))
			bus.rdata = bus.flp_high;
		else if (hit(bus.dev, bus.addr, DEV_LINKUP, REG_LINKUP))
			bus.rdata = {7'h00, linkup};
		else if (hit(bus.dev, bus.addr, DEV_COMMON, REG_COMMON)) begin
			bus.rdata = common_rw;
			bus.rdata[MODE_BIT] = bus.style_status;
		end
	end

	a_lo_reset_val: assert property (@(posedge clk_i) $rose(rst_n_i) |->
		bus.flp_low == FLP_LOW_8MS) else $error("low burst reset wrong");
	a_hi_reset_val: assert property (@(posedge clk_i) $rose(rst_n_i) |->
		bus.flp_high == FLP_HIGH_8MS) else $error("high burst reset wrong");
	a_linkup_write: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		bus.wr && hit(bus.dev, bus.addr, DEV_LINKUP, REG_LINKUP) |=>
		bus.linkup_time == $past(bus.wdata[LUT_HI:LUT_LO]))
		else $error("link-up time not stored");
	a_override_reads0: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		hit(bus.dev, bus.addr, DEV_COMMON, REG_COMMON) |-> !bus.rdata[OVR_BIT] &&
		bus.rdata[MODE_BIT] == bus.style_status)
		else $error("override bit read not zero");
	a_override_copy: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		wr_common |=> bus.style_status == $past(bus.wdata[OVR_BIT]))
		else $error("override not copied to status");
	a_mode_stable: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		!wr_common && !bus.strap_load |=> $stable(bus.style_status))
		else $error("indicator status changed unprompted");
endmodule
`default_nettype wire

// *** design/pmt_bank_if.sv ***
/*
 * Carrier between the portal and the register bank.
 * Assumes both ends run on the same management clock.
 */
`timescale 1ns/1ns
`default_nettype none
interface pmt_bank_if;
	logic wr;
	logic [4:0] dev;
	logic [15:0] addr;
	logic [15:0] wdata;
	logic [15:0] rdata;
	logic strap;
	logic strap_load;
	logic style_status;
	logic [15:0] flp_low;
	logic [15:0] flp_high;
	logic [2:0] linkup_time;
	modport portal (output wr, dev, addr, wdata, strap, strap_load,
		input rdata, style_status, flp_low, flp_high, linkup_time);
	modport bank (input wr, dev, addr, wdata, strap, strap_load,
		output rdata, style_status, flp_low, flp_high, linkup_time);
endinterface
`default_nettype wire

// *** design/pmt_pkg.sv ***
/*
 * Constants for the management timing and indicator register bank.
 * Assumes a single management clock and an active-low chip reset.
 */
// Overview of operation
// - Low burst: 4000h 8 ms, 1A80h 16 ms
// - High burst: 0003h 8 ms, 0006h 16 ms
// - Three-bit link-up time in bits 3:1, reset 100
// - Override bit 4 is write-only, reads zero
// - Written override copies into status bit 3
// - Status loads from strap pin, then only override
// - Value 1 single indicator, 0 tri-color dual
// - Portal ops: address, data, increment variants
`default_nettype none
package pmt_pkg;
	// Portal register addresses on the management port
	localparam logic [4:0] PORTAL_CTL_ADDR = 5'h0D;
	localparam logic [4:0] PORTAL_DATA_ADDR = 5'h0E;
	localparam int OP_HI = 15;
	localparam int OP_LO = 14;
	localparam int DEVAD_HI = 4;
	localparam logic [15:0] PORTAL_CTL_MASK = 16'hC01F;
	localparam logic [1:0] OP_ADDRESS = 2'h0;
	localparam logic [1:0] OP_DATA_NOINC = 2'h1;
	localparam logic [1:0] OP_DATA_INC_RW = 2'h2;
	localparam logic [1:0] OP_DATA_INC_WR = 2'h3;
	// Bank device addresses and register offsets
	localparam logic [4:0] DEV_AUTONEG = 5'h00;
	localparam logic [4:0] DEV_LINKUP = 5'h01;
	localparam logic [4:0] DEV_COMMON = 5'h02;
	localparam logic [15:0] REG_FLP_LOW = 16'h0003;
	localparam logic [15:0] REG_FLP_HIGH = 16'h0004;
	localparam logic [15:0] REG_LINKUP = 16'h005A;
	localparam logic [15:0] REG_COMMON = 16'h0000;
	// Burst interval encodings and resets
	localparam logic [15:0] FLP_LOW_8MS = 16'h4000;
	localparam logic [15:0] FLP_LOW_16MS = 16'h1A80;
	localparam logic [15:0] FLP_HIGH_8MS = 16'h0003;
	localparam logic [15:0] FLP_HIGH_16MS = 16'h0006;
	// Link-up register: bits 8:0 writable, 15:9 read zero
	localparam logic [8:0] LINKUP_RST = 9'h108;
	localparam int LINKUP_W = 9;
	localparam int LUT_HI = 3;
	localparam int LUT_LO = 1;
	// Common control: bit 4 write-only, bit 3 status
	localparam int OVR_BIT = 4;
	localparam int MODE_BIT = 3;
	localparam logic [15:0] COMMON_RW_MASK = 16'hFFE7;
	localparam logic [15:0] COMMON_RST = 16'h0000;
	// Strap settling: edges after release before capture
	localparam logic [1:0] STRAP_SETTLE = 2'h2;
	localparam logic [1:0] STRAP_DONE = 2'h3;
endpackage
`default_nettype wire

// *** design/pmt_top.sv ***
/*
 * Management portal, strap capture and burst spacing counter.
 * Assumes the management front end delivers clause-22 register
 * accesses as one-cycle strobes on the system clock.
 */
`timescale 1ns/1ns
`default_nettype none
module pmt_top
	import pmt_pkg::*;
#(
	parameter int DEVS = 32
) (
	input wire logic SYS_CLK_I,
	input wire logic RESET_N_I,
	input wire logic [4:0] REG_ADDR_I,
	input wire logic [15:0] REG_WDATA_I,
	input wire logic REG_WR_I,
	input wire logic REG_RD_I,
	output logic [15:0] REG_RDATA_O,
	output logic REG_RVALID_O,
	input wire logic INDICATOR_STYLE_STRAP_I,
	input wire logic AN_START_I,
	output logic FLP_BURST_O,
	output logic FLP_LONG_O,
	output logic INDICATOR_SINGLE_O,
	output logic [2:0] LINKUP_TIME_O
);
	pmt_bank_if bus ();

	logic [1:0] op;
	logic [4:0] devad;
	logic [15:0] reg_addr [DEVS];
	logic strap_meta;
	logic strap_sync;
	logic [1:0] strap_cnt;
	logic [31:0] burst_cnt;
	logic burst_run;
	logic wr_ctl;
	logic wr_data;
	logic rd_data;
	logic inc;

	// Post-increment decision per operation
	function automatic logic bump(input logic [1:0] o, input logic is_wr);
		bump = (o == OP_DATA_INC_RW) || (is_wr && o == OP_DATA_INC_WR);
	endfunction

	// Portal strobes and bank request
	always_comb begin
		wr_ctl = REG_WR_I && REG_ADDR_I == PORTAL_CTL_ADDR;
		wr_data = REG_WR_I && REG_ADDR_I == PORTAL_DATA_ADDR;
		rd_data = REG_RD_I && REG_ADDR_I == PORTAL_DATA_ADDR;
		inc = op != OP_ADDRESS && ((wr_data && bump(op, 1'b1)) ||
			(rd_data && bump(op, 1'b0)));
		bus.wr = wr_data && op != OP_ADDRESS;
		bus.dev = devad;
		bus.addr = reg_addr[devad];
		bus.wdata = REG_WDATA_I;
		bus.strap = strap_sync;
		bus.strap_load = strap_cnt == STRAP_SETTLE;
	end

	// Portal control register
	always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			op <= OP_ADDRESS;
			devad <= 5'h00;
		end else if (wr_ctl) begin
			op <= REG_WDATA_I[OP_HI:OP_LO];
			devad <= REG_WDATA_I[DEVAD_HI:0];
		end
	end

	// Per-device register address with post-increment
	always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			for (int i = 0; i < DEVS; i++)
				reg_addr[i] <= 16'h0000;
		end else if (wr_data && op == OP_ADDRESS) begin
			reg_addr[devad] <= REG_WDATA_I;
		end else if (inc) begin
			reg_addr[devad] <= reg_addr[devad] + 16'h0001;
		end
	end

	// Read answer one cycle after the strobe
	always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			REG_RDATA_O <= 16'h0000;
			REG_RVALID_O <= 1'b0;
		end else begin
			REG_RVALID_O <= REG_RD_I;
			if (REG_RD_I) begin
				if (REG_ADDR_I == PORTAL_CTL_ADDR)
					REG_RDATA_O <= {op, 14'h0000} | {11'h000, devad};
				else if (REG_ADDR_I == PORTAL_DATA_ADDR)
					REG_RDATA_O <= op == OP_ADDRESS ? bus.addr : bus.rdata;
				else
					REG_RDATA_O <= 16'h0000;
			end
		end
	end

	// Strap pin synchroniser and one-shot capture after release
	always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			strap_meta <= 1'b0;
			strap_sync <= 1'b0;
			strap_cnt <= 2'h0;
		end else begin
			strap_meta <= INDICATOR_STYLE_STRAP_I;
			strap_sync <= strap_meta;
			if (strap_cnt != STRAP_DONE)
				strap_cnt <= strap_cnt + 2'h1;
		end
	end

	// Burst spacing counter reloaded from the joined registers
	always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			burst_cnt <= 32'h0000_0000;
			burst_run <= 1'b0;
			FLP_BURST_O <= 1'b0;
		end else begin
			FLP_BURST_O <= 1'b0;
			if (AN_START_I) begin
				burst_cnt <= {bus.flp_high, bus.flp_low};
				burst_run <= 1'b1;
			end else if (burst_run) begin
				if (burst_cnt == 32'h0000_0000) begin
					burst_cnt <= {bus.flp_high, bus.flp_low};
					FLP_BURST_O <= 1'b1;
				end else begin
					burst_cnt <= burst_cnt - 32'h0000_0001;
				end
			end
		end
	end

	// Decoded selections and configuration outputs
	always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			FLP_LONG_O <= 1'b0;
			INDICATOR_SINGLE_O <= 1'b0;
			LINKUP_TIME_O <= 3'h0;
		end else begin
			FLP_LONG_O <= bus.flp_low == FLP_LOW_16MS && bus.flp_high == FLP_HIGH_16MS;
			INDICATOR_SINGLE_O <= bus.style_status;
			LINKUP_TIME_O <= bus.linkup_time;
		end
	end

	pmt_bank u_bank (
		.clk_i(SYS_CLK_I),
		.rst_n_i(RESET_N_I),
		.bus(bus)
	);

	a_long_decode: assert property (@(posedge SYS_CLK_I) disable iff (!RESET_N_I)
		bus.flp_low == FLP_LOW_16MS && bus.flp_high == FLP_HIGH_16MS |=> FLP_LONG_O)
		else $error("16 ms selection not decoded");
	a_short_decode: assert property (@(posedge SYS_CLK_I) disable iff (!RESET_N_I)
		bus.flp_high == FLP_HIGH_8MS |=> !FLP_LONG_O)
		else $error("8 ms selection not decoded");
	a_long_reserved: assert property (@(posedge SYS_CLK_I) disable iff (!RESET_N_I)
		!(bus.flp_low == FLP_LOW_16MS && bus.flp_high == FLP_HIGH_16MS) |=> !FLP_LONG_O)
		else $error("long selection without both codes");
	a_style_follows: assert property (@(posedge SYS_CLK_I) disable iff (!RESET_N_I)
		##1 INDICATOR_SINGLE_O == $past(bus.style_status))
		else $error("indicator output lags status");
	a_linkup_out: assert property (@(posedge SYS_CLK_I) disable iff (!RESET_N_I)
		RESET_N_I |=> LINKUP_TIME_O == $past(bus.linkup_time))
		else $error("link-up time output lags field");

	// Portal control, pointer and read answer checks
	a_portal_incr: assert property (@(posedge SYS_CLK_I) disable iff (!RESET_N_I)
		rd_data && op == OP_DATA_INC_RW |=>
		reg_addr[$past(devad)] == $past(bus.addr) + 16'h0001)
		else $error("read post-increment missing");
	a_portal_noinc: assert property (@(posedge SYS_CLK_I) disable iff (!RESET_N_I)
		rd_data && !REG_WR_I && op == OP_DATA_INC_WR |=>
		reg_addr[$past(devad)] == $past(bus.addr))
		else $error("write-only increment moved on read");
	a_ctl_write: assert property (@(posedge SYS_CLK_I) disable iff (!RESET_N_I)
		wr_ctl |=> op == $past(REG_WDATA_I[OP_HI:OP_LO]) &&
		devad == $past(REG_WDATA_I[DEVAD_HI:0]))
		else $error("portal control not stored");
	a_addr_readback: assert property (@(posedge SYS_CLK_I) disable iff (!RESET_N_I)
		rd_data && op == OP_ADDRESS |=> REG_RDATA_O == $past(bus.addr))
		else $error("stored address not read back");
	a_write_incr: assert property (@(posedge SYS_CLK_I) disable iff (!RESET_N_I)
		wr_data && (op == OP_DATA_INC_WR || op == OP_DATA_INC_RW) |=>
		reg_addr[$past(devad)] == $past(bus.addr) + 16'h0001)
		else $error("write post-increment missing");
	a_noinc_hold: assert property (@(posedge SYS_CLK_I) disable iff (!RESET_N_I)
		(wr_data || rd_data) && op == OP_DATA_NOINC |=>
		reg_addr[$past(devad)] == $past(bus.addr))
		else $error("address moved without increment");
	a_rvalid_follows: assert property (@(posedge SYS_CLK_I) disable iff (!RESET_N_I)
		RESET_N_I |=> REG_RVALID_O == $past(REG_RD_I))
		else $error("read answer not one cycle after strobe");
	a_rdata_hold: assert property (@(posedge SYS_CLK_I) disable iff (!RESET_N_I)
		!REG_RD_I |=> $stable(REG_RDATA_O))
		else $error("read data changed without a read");

	// Strap capture checks
	a_strap_capture: assert property (@(posedge SYS_CLK_I) disable iff (!RESET_N_I)
		bus.strap_load && !(bus.wr && bus.dev == DEV_COMMON && bus.addr == REG_COMMON) |=>
		bus.style_status == $past(strap_sync))
		else $error("strap not captured into status");
	a_strap_once: assert property (@(posedge SYS_CLK_I) disable iff (!RESET_N_I)
		strap_cnt == STRAP_DONE |=> strap_cnt == STRAP_DONE)
		else $error("strap capture repeated");

	// Burst spacing checks
	a_burst_reload: assert property (@(posedge SYS_CLK_I) disable iff (!RESET_N_I)
		AN_START_I |=> burst_run && burst_cnt == $past({bus.flp_high, bus.flp_low}))
		else $error("spacing counter not reloaded");
	a_burst_pulse: assert property (@(posedge SYS_CLK_I) disable iff (!RESET_N_I)
		burst_run && !AN_START_I && burst_cnt == 32'h0000_0000 |=> FLP_BURST_O)
		else $error("burst pulse missing at count end");
	a_burst_quiet: assert property (@(posedge SYS_CLK_I) disable iff (!RESET_N_I)
		!burst_run |=> !FLP_BURST_O)
		else $error("burst pulse while spacing idle");
endmodule
`default_nettype wire

// *** verif/pmt_host.sv ***
/*
 * Management host model: drives the clause-22 register port.
 * Assumes one-cycle strobes and a read answer one edge later.
 */
`timescale 1ns/1ns
`default_nettype none
module pmt_host
	import pmt_pkg::*;
(
	input wire logic clk_i,
	output logic [4:0] addr_o,
	output logic [15:0] wdata_o,
	output logic wr_o,
	output logic rd_o,
	input wire logic [15:0] rdata_i,
	input wire logic rvalid_i
);
	// Idle port at time zero
	initial begin
		addr_o = 5'h00;
		wdata_o = 16'h0000;
		wr_o = 1'b0;
		rd_o = 1'b0;
	end

	// One access; idle data turns inverse so stale values never match
	task automatic acc(input logic w, input logic [4:0] a, input logic [15:0] d,
		output logic [15:0] q);
		int n;
		q = 16'hXXXX;
		@(posedge clk_i);
		addr_o <= a;
		wdata_o <= d;
		wr_o <= w;
		rd_o <= !w;
		@(posedge clk_i);
		wr_o <= 1'b0;
		rd_o <= 1'b0;
		wdata_o <= ~d;
		// Answer stands for the cycle after the taking edge; look once settled
		for (n = 0; n < 4 && !w; n++) begin
			#1;
			if (rvalid_i === 1'b1) begin
				q = rdata_i;
				break;
			end
			@(posedge clk_i);
		end
	endtask

	// Indirect write: address setup, then data without increment
	task automatic mmd_wr(input logic [4:0] dv, input logic [15:0] ra, input logic [15:0] v);
		logic [15:0] q;
		acc(1'b1, PORTAL_CTL_ADDR, {11'h000, dv}, q);
		acc(1'b1, PORTAL_DATA_ADDR, ra, q);
		acc(1'b1, PORTAL_CTL_ADDR, {OP_DATA_NOINC, 9'h000, dv}, q);
		acc(1'b1, PORTAL_DATA_ADDR, v, q);
	endtask

	// Indirect read through the same portal sequence
	task automatic mmd_rd(input logic [4:0] dv, input logic [15:0] ra, output logic [15:0] q);
		acc(1'b1, PORTAL_CTL_ADDR, {11'h000, dv}, q);
		acc(1'b1, PORTAL_DATA_ADDR, ra, q);
		acc(1'b1, PORTAL_CTL_ADDR, {OP_DATA_NOINC, 9'h000, dv}, q);
		acc(1'b0, PORTAL_DATA_ADDR, 16'h0000, q);
	endtask
endmodule
`default_nettype wire

// *** verif/tb_phy_mmd_timing_led_config.sv ***
/*
 * Self-checking bench for the timing and indicator register bank.
 * Assumes the host model owns the register port.
 */
`timescale 1ns/1ns
`default_nettype none
module tb_phy_mmd_timing_led_config;
	import pmt_pkg::*;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic strap = 1'b1;
	logic an_start = 1'b0;
	logic [4:0] addr;
	logic [15:0] wdata, rdata, q;
	logic wr, rd, rvalid, burst, long_sel, single;
	logic [2:0] lut;
	int mismatches = 0;
	int check_count = 0;
	int n;

	// 25 MHz clock
	always #20 clk = ~clk;

	pmt_top i_pmt_top (.SYS_CLK_I(clk), .RESET_N_I(rst_n), .REG_ADDR_I(addr),
		.REG_WDATA_I(wdata), .REG_WR_I(wr), .REG_RD_I(rd), .REG_RDATA_O(rdata),
		.REG_RVALID_O(rvalid), .INDICATOR_STYLE_STRAP_I(strap), .AN_START_I(an_start),
		.FLP_BURST_O(burst), .FLP_LONG_O(long_sel), .INDICATOR_SINGLE_O(single),
		.LINKUP_TIME_O(lut));
	pmt_host i_pmt_host (.clk_i(clk), .addr_o(addr), .wdata_o(wdata), .wr_o(wr),
		.rd_o(rd), .rdata_i(rdata), .rvalid_i(rvalid));

	// Compare and count
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp) begin
			mismatches++;
			$display("Error %0t got %h expected %h", $time, got, exp);
		end
	endtask

	// Indirect read and compare
	task automatic rchk(input logic [4:0] dv, input logic [15:0] ra, input logic [15:0] exp);
		i_pmt_host.mmd_rd(dv, ra, q);
		chk(q, exp);
	endtask

	// Let a write reach the registered outputs
	task automatic settle();
		repeat (2) @(posedge clk);
		#1;
	endtask

	task automatic close_out();
		$display("Counts: %0d mismatches in %0d checks", mismatches, check_count);
		if (mismatches == 0 && check_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// Main sequence
	initial begin
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		repeat (6) @(posedge clk);
		#1;
		chk({13'h0000, lut}, 16'h0004);
		chk({15'h0000, single}, 16'h0001);
		chk({15'h0000, long_sel}, 16'h0000);
		rchk(DEV_AUTONEG, REG_FLP_LOW, 16'h4000);
		rchk(DEV_AUTONEG, REG_FLP_HIGH, 16'h0003);
		rchk(DEV_LINKUP, REG_LINKUP, 16'h0108);
		rchk(DEV_COMMON, REG_COMMON, 16'h0008);
		// Long interval on both halves
		i_pmt_host.mmd_wr(DEV_AUTONEG, REG_FLP_LOW, 16'h1A80);
		i_pmt_host.mmd_wr(DEV_AUTONEG, REG_FLP_HIGH, 16'h0006);
		settle();
		chk({15'h0000, long_sel}, 16'h0001);
		rchk(DEV_AUTONEG, REG_FLP_LOW, 16'h1A80);
		// Link-up field, reserved top bits stay zero
		i_pmt_host.mmd_wr(DEV_LINKUP, REG_LINKUP, 16'hFFFF);
		rchk(DEV_LINKUP, REG_LINKUP, 16'h01FF);
		chk({13'h0000, lut}, 16'h0007);
		// Override to dual, then to single against the pin
		i_pmt_host.mmd_wr(DEV_COMMON, REG_COMMON, 16'h0000);
		rchk(DEV_COMMON, REG_COMMON, 16'h0000);
		chk({15'h0000, single}, 16'h0000);
		strap <= 1'b0;
		i_pmt_host.mmd_wr(DEV_COMMON, REG_COMMON, 16'h0010);
		rchk(DEV_COMMON, REG_COMMON, 16'h0008);
		chk({15'h0000, single}, 16'h0001);
		// Increment on writes only: low then high
		i_pmt_host.acc(1'b1, PORTAL_CTL_ADDR, 16'h0000, q);
		i_pmt_host.acc(1'b1, PORTAL_DATA_ADDR, REG_FLP_LOW, q);
		i_pmt_host.acc(1'b1, PORTAL_CTL_ADDR, 16'hC000, q);
		i_pmt_host.acc(1'b0, PORTAL_DATA_ADDR, 16'h0000, q);
		chk(q, 16'h1A80);
		i_pmt_host.acc(1'b1, PORTAL_DATA_ADDR, 16'h4000, q);
		i_pmt_host.acc(1'b1, PORTAL_DATA_ADDR, 16'h0003, q);
		// Increment on reads and writes, driven here with reads only: low then high
		i_pmt_host.acc(1'b1, PORTAL_CTL_ADDR, 16'h0000, q);
		i_pmt_host.acc(1'b1, PORTAL_DATA_ADDR, REG_FLP_LOW, q);
		i_pmt_host.acc(1'b0, PORTAL_DATA_ADDR, 16'h0000, q);
		chk(q, 16'h0003);
		i_pmt_host.acc(1'b1, PORTAL_CTL_ADDR, 16'h8000, q);
		i_pmt_host.acc(1'b0, PORTAL_CTL_ADDR, 16'h0000, q);
		chk(q, 16'h8000);
		i_pmt_host.acc(1'b0, PORTAL_DATA_ADDR, 16'h0000, q);
		chk(q, 16'h4000);
		i_pmt_host.acc(1'b0, PORTAL_DATA_ADDR, 16'h0000, q);
		chk(q, 16'h0003);
		i_pmt_host.acc(1'b0, 5'h01, 16'h0000, q);
		chk(q, 16'h0000);
		// Short spacing count: first burst after count plus one edges
		i_pmt_host.mmd_wr(DEV_AUTONEG, REG_FLP_HIGH, 16'h0000);
		i_pmt_host.mmd_wr(DEV_AUTONEG, REG_FLP_LOW, 16'h0004);
		@(posedge clk);
		an_start <= 1'b1;
		@(posedge clk);
		an_start <= 1'b0;
		n = 0;
		while (burst !== 1'b1 && n < 20) begin
			@(posedge clk);
			#1;
			n++;
		end
		chk(16'(n), 16'h0005);
		// Mid-run reset with the strap pin now low
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		repeat (6) @(posedge clk);
		#1;
		chk({15'h0000, single}, 16'h0000);
		chk({13'h0000, lut}, 16'h0004);
		rchk(DEV_AUTONEG, REG_FLP_LOW, 16'h4000);
		rchk(DEV_COMMON, REG_COMMON, 16'h0000);
		close_out();
	end
endmodule
`default_nettype wire
